//--- hdl/uvol_pkg.sv
package uvol_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NCH = 4;
	localparam int SYNC_W = 15;
	localparam int SYNC_STAGES = 2;

	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_CFG = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_MASK = 8'h0C;
	localparam logic [7:0] ADDR_LIVE = 8'h10;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CFG_UVDIS_BIT = 0;
	localparam int CFG_OLDIS_LSB = 1;
	localparam int ST_UV_BIT = 0;
	localparam int ST_OL_LSB = 1;
	localparam int LIVE_LATCH_LSB = 4;
	localparam int LIVE_LOW_BIT = 8;
	localparam int LIVE_POR_BIT = 9;
	localparam int LIVE_CRIT_BIT = 10;
	localparam int LIVE_PIN_BIT = 11;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [3:0] ol_disable;
		logic undervoltage_protect_disable;
	} uvol_cfg_t;

	typedef struct packed {
		logic [3:0] open_load_flag;
		logic undervoltage_flag;
	} uvol_stat_t;

	typedef struct packed {
		logic [3:0] gate_off;
		logic [3:0] open_load;
		logic battery_crit_low;
		logic battery_por_low;
		logic battery_low;
	} uvol_ana_t;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] CMD_RST = 4'h0;
	localparam uvol_cfg_t CFG_RST = 5'h00;
	localparam uvol_stat_t STAT_RST = 5'h00;
	localparam uvol_stat_t MASK_RST = 5'h00;
	localparam logic [31:0] RDATA_RST = 32'h00000000;

endpackage

//--- hdl/uvol_fault.sv
// What this block does
// - Battery low, protection on: outputs off, pin low above the reset threshold, flag set.
// - Recovery, commands low: pin high at once, flag kept until read.
// - Recovery, command on: output off, pin low until re-command.
// - Protection off: no pin report, flag set, outputs kept above crit.
// - Logic and register state survive a battery undervoltage event.
// - Serial/register path keeps working without battery supply.
// - Open load is judged only while that output is off.
// - Open load latches only once the gate is pulled low enough.
// - Open-load flag stays until a read after the condition is gone.
// - Per-channel disable bit suppresses open-load detection.
// - A latched fault releases the pin only on a new switch-on command or below the reset threshold.
// - First status read returns the fault flags and clears those whose cause is gone.
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module uvol_fault (
	input wire logic clk, // 10 MHz system clock
	input wire logic rst, // asynchronous, active high
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire uvol_pkg::uvol_ana_t ana_async, // comparator outputs
	input wire logic [3:0] direct_in, // direct on inputs, async pins
	output logic [3:0] out_en, // gate drive enable per channel
	output logic fault_flag_pin_n, // fault pin, low on fault
	output logic irq // level interrupt
);

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [uvol_pkg::SYNC_W-1:0] sync_raw;
	logic [uvol_pkg::SYNC_W-1:0] sync_a_reg;
	logic [uvol_pkg::SYNC_W-1:0] sync_b_reg;

	assign sync_raw = {direct_in, ana_async};

	genvar gs;
	generate
		for (gs = 0; gs < uvol_pkg::SYNC_W; gs++) begin : g_sync
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					sync_a_reg[gs] <= 1'b0;
					sync_b_reg[gs] <= 1'b0;
				end else begin
					sync_a_reg[gs] <= sync_raw[gs];
					sync_b_reg[gs] <= sync_a_reg[gs];
				end
			end
		end
	endgenerate

	uvol_pkg::uvol_ana_t ana;
	logic [3:0] din;
	assign ana = sync_b_reg[10:0];
	assign din = sync_b_reg[14:11];

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// None of these is reset by the battery comparators, so contents
	// ride through any battery dip while the clock and rst are stable.
	logic [3:0] cmd_reg;
	uvol_pkg::uvol_cfg_t cfg_reg;
	uvol_pkg::uvol_stat_t status_reg;
	uvol_pkg::uvol_stat_t mask_reg;
	uvol_pkg::uvol_stat_t snap_reg;
	logic [3:0] cmd_q_reg;
	logic [3:0] latch_reg;
	logic [3:0] out_next;
	logic pin_low_next;
	logic [3:0] ol_cond;
	uvol_pkg::uvol_stat_t set_vec;
	uvol_pkg::uvol_stat_t status_next;

	// ----------------------------------------------------------------
	// APB slave, no wait state; read data comes from a flop loaded in setup
	// ----------------------------------------------------------------
	logic setup;
	logic access;
	logic addr_hit;
	logic wr_en;
	logic rd_clr;
	logic [31:0] rd_mux;

	assign setup = psel & ~penable;
	assign access = psel & penable & pready;
	assign wr_en = access & pwrite & ~pslverr;
	assign rd_clr = access & ~pwrite & ~pslverr &
		(paddr == uvol_pkg::ADDR_STATUS);

	always_comb begin
		addr_hit = 1'b1;
		rd_mux = 32'h00000000;
		unique case (paddr)
			uvol_pkg::ADDR_CMD: rd_mux[3:0] = cmd_reg;
			uvol_pkg::ADDR_CFG: rd_mux[4:0] = cfg_reg;
			uvol_pkg::ADDR_STATUS: rd_mux[4:0] = status_reg;
			uvol_pkg::ADDR_MASK: rd_mux[4:0] = mask_reg;
			uvol_pkg::ADDR_LIVE: begin
				rd_mux[3:0] = out_en;
				rd_mux[uvol_pkg::LIVE_LATCH_LSB +: 4] = latch_reg;
				rd_mux[uvol_pkg::LIVE_LOW_BIT] = ana.battery_low;
				rd_mux[uvol_pkg::LIVE_POR_BIT] = ana.battery_por_low;
				rd_mux[uvol_pkg::LIVE_CRIT_BIT] = ana.battery_crit_low;
				rd_mux[uvol_pkg::LIVE_PIN_BIT] = fault_flag_pin_n;
			end
			default: addr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			pslverr <= setup & ~addr_hit;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata <= uvol_pkg::RDATA_RST;
		end else if (setup & ~pwrite) begin
			prdata <= rd_mux;
		end
	end

	// Only bits actually returned to software may be cleared; an event
	// landing between setup and access stays pending.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			snap_reg <= uvol_pkg::STAT_RST;
		end else if (setup) begin
			snap_reg <= (paddr == uvol_pkg::ADDR_STATUS) ?
				status_reg : uvol_pkg::STAT_RST;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmd_reg <= uvol_pkg::CMD_RST;
			cfg_reg <= uvol_pkg::CFG_RST;
			mask_reg <= uvol_pkg::MASK_RST;
		end else if (wr_en) begin
			if (paddr == uvol_pkg::ADDR_CMD)
				cmd_reg <= pwdata[3:0];
			if (paddr == uvol_pkg::ADDR_CFG)
				cfg_reg <= pwdata[4:0];
			if (paddr == uvol_pkg::ADDR_MASK)
				mask_reg <= pwdata[4:0];
		end
	end

	// ----------------------------------------------------------------
	// Undervoltage decisions
	// ----------------------------------------------------------------
	logic [3:0] cmd;
	logic uv_prot;

	assign cmd = cmd_reg | din;
	assign uv_prot = ana.battery_low &
		~cfg_reg.undervoltage_protect_disable;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmd_q_reg <= uvol_pkg::CMD_RST;
		end else begin
			cmd_q_reg <= cmd;
		end
	end

	genvar gc;
	generate
		for (gc = 0; gc < uvol_pkg::NCH; gc++) begin : g_ch
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					latch_reg[gc] <= 1'b0;
				end else if (uv_prot & cmd[gc]) begin
					latch_reg[gc] <= 1'b1;
				end else if (cmd[gc] & ~cmd_q_reg[gc]) begin
					latch_reg[gc] <= 1'b0;
				end
			end

			// Disabled protection still drops the output below crit
			assign out_next[gc] = cmd[gc] & ~latch_reg[gc] & ~uv_prot &
				~ana.battery_crit_low;

			assign ol_cond[gc] = ana.open_load[gc] & ~out_en[gc] &
				ana.gate_off[gc] &
				~cfg_reg.ol_disable[gc];
		end
	endgenerate

	// Below the reset threshold only open load can pull the pin low, latch is kept
	assign pin_low_next = ((uv_prot | (|latch_reg)) &
		~ana.battery_por_low) | (|ol_cond);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_en <= 4'h0;
			fault_flag_pin_n <= 1'b1;
		end else begin
			out_en <= out_next;
			fault_flag_pin_n <= ~pin_low_next;
		end
	end

	// ----------------------------------------------------------------
	// Sticky status and interrupt
	// ----------------------------------------------------------------
	// Set wins over the read clear, so a flag whose cause persists
	// survives the read and a freshly removed cause clears.
	assign set_vec = {ol_cond, ana.battery_low};
	assign status_next = (status_reg & ~(rd_clr ? snap_reg :
		uvol_pkg::STAT_RST)) | set_vec;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status_reg <= uvol_pkg::STAT_RST;
			irq <= 1'b0;
		end else begin
			status_reg <= status_next;
			irq <= |(status_reg & mask_reg);
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_uv_off;
		uv_prot |=> (out_en == 4'h0);
	endproperty
	a_uv_off: assert property (p_uv_off)
		else $error("outputs not off in undervoltage");

	property p_uv_pin;
		uv_prot && !ana.battery_por_low |=> !fault_flag_pin_n;
	endproperty
	a_uv_pin: assert property (p_uv_pin)
		else $error("fault pin not low in undervoltage");

	property p_uv_flag;
		ana.battery_low |=> status_reg.undervoltage_flag;
	endproperty
	a_uv_flag: assert property (p_uv_flag)
		else $error("undervoltage flag not set");

	property p_recover_pin;
		!uv_prot && latch_reg == 4'h0 && ol_cond == 4'h0
			|=> fault_flag_pin_n;
	endproperty
	a_recover_pin: assert property (p_recover_pin)
		else $error("fault pin low after recovery");

	property p_latch_hold;
		latch_reg[0] && !(cmd[0] && !cmd_q_reg[0])
			|=> latch_reg[0] && !out_en[0];
	endproperty
	a_latch_hold: assert property (p_latch_hold)
		else $error("latched output released without re-command");

	property p_uvdis_out;
		cfg_reg.undervoltage_protect_disable &&
			!ana.battery_crit_low && latch_reg == 4'h0
			|=> out_en == $past(cmd);
	endproperty
	a_uvdis_out: assert property (p_uvdis_out)
		else $error("output changed with protection disabled");

	property p_crit_off;
		ana.battery_crit_low |=> out_en == 4'h0;
	endproperty
	a_crit_off: assert property (p_crit_off)
		else $error("output on below the critical supply level");

	property p_recmd;
		latch_reg[0] && cmd[0] && !cmd_q_reg[0] && !uv_prot
			|=> !latch_reg[0];
	endproperty
	a_recmd: assert property (p_recmd)
		else $error("new switch-on command did not release latch");

	property p_ol_pin;
		ol_cond != 4'h0 |=> !fault_flag_pin_n;
	endproperty
	a_ol_pin: assert property (p_ol_pin)
		else $error("open load not shown on fault pin");

	// Per channel, so the checks see whichever channel loses its load
	genvar ga;
	generate
		for (ga = 0; ga < uvol_pkg::NCH; ga++) begin : g_ola
			property p_ol_when_off;
				$rose(status_reg.open_load_flag[ga])
					|-> $past(!out_en[ga] && ana.gate_off[ga]);
			endproperty
			a_ol_when_off: assert property (p_ol_when_off)
				else $error("open load flagged with output on");

			property p_open_load_detect_disable;
				cfg_reg.ol_disable[ga] && !status_reg.open_load_flag[ga]
					|=> !status_reg.open_load_flag[ga];
			endproperty
			a_open_load_detect_disable: assert property (p_open_load_detect_disable)
				else $error("open load set while disabled");

			property p_ol_hold;
				status_reg.open_load_flag[ga] && !rd_clr
					|=> status_reg.open_load_flag[ga];
			endproperty
			a_ol_hold: assert property (p_ol_hold)
				else $error("open load flag lost without read");
		end
	endgenerate

	property p_rd_clr;
		rd_clr && snap_reg.undervoltage_flag && !ana.battery_low
			|=> !status_reg.undervoltage_flag;
	endproperty
	a_rd_clr: assert property (p_rd_clr)
		else $error("status read did not clear flag");

	property p_irq;
		(status_reg & mask_reg) != 5'h00 |=> irq;
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt not raised");

	c_uv_latch: cover property (latch_reg[0] ##[1:50] !latch_reg[0]);
	c_rd_clr: cover property (rd_clr && snap_reg != 5'h00);
	c_ol_flag: cover property ($rose(|status_reg.open_load_flag));
	c_uvdis_on: cover property (cfg_reg.undervoltage_protect_disable &&
		ana.battery_low && out_en != 4'h0);

endmodule

//--- dv/uvol_host.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host controller model: APB master
// ----------------------------------------------------------------
module uvol_host (
	input wire logic clk, // system clock
	input wire logic [31:0] prdata, // read data
	input wire logic pready, // slave ready
	input wire logic pslverr, // slave error
	output logic psel, // select
	output logic penable, // enable
	output logic pwrite, // direction
	output logic [7:0] paddr, // byte address
	output logic [31:0] pwdata // write data
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
	end

	// Answer is taken at the rising edge that samples pready high; the
	// task wakes there before the design's updates for that edge land
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e,
		output logic ok);
		int n;
		ok = 1'b0;
		q = 32'h00000000;
		e = 1'b0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (n = 0; n < 16 && !ok; n++) begin
			@(posedge clk);
			if (pready === 1'b1) begin
				ok = 1'b1;
				q = prdata;
				e = pslverr;
			end
		end
		psel <= 1'b0;
		penable <= 1'b0;
		// Released data lines do not keep the last value
		pwdata <= ~d;
	endtask
endmodule

//--- dv/testbench.sv
`timescale 1ns/1ps
module testbench;
	typedef struct packed {
		logic [4:0] cfg;
		logic [3:0] cmd;
		logic [10:0] ana;
		logic [3:0] oe;
		logic pin;
	} uvol_row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel, penable, pwrite, pslverr, pready, pin_n, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic e;
	uvol_pkg::uvol_ana_t ana = 11'h000;
	logic [3:0] din = 4'h0;
	logic [3:0] oe;
	int bad_count = 0;
	int compares = 0;
	uvol_row_t rows [6] = '{
		'{5'h00, 4'hF, 11'h000, 4'hF, 1'b1},
		'{5'h00, 4'h5, 11'h000, 4'h5, 1'b1},
		'{5'h01, 4'hF, 11'h001, 4'hF, 1'b1},
		'{5'h01, 4'hF, 11'h007, 4'h0, 1'b1},
		'{5'h00, 4'h0, 11'h003, 4'h0, 1'b1},
		'{5'h00, 4'h0, 11'h000, 4'h0, 1'b1}};
	logic [7:0] regs [4] = '{uvol_pkg::ADDR_CMD, uvol_pkg::ADDR_CFG,
		uvol_pkg::ADDR_STATUS, uvol_pkg::ADDR_MASK};

	always #50 clk = ~clk;

	uvol_host host (.clk(clk), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

	uvol_fault dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ana_async(ana),
		.direct_in(din), .out_en(oe), .fault_flag_pin_n(pin_n), .irq(irq));

	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t %s got %h want %h", $time, m, got, exp);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		logic ok;
		host.xfer(w, a, d, q, e, ok);
		if (!ok) begin
			bad_count++;
			$display("ERROR %0t bus timeout", $time);
			print_verdict();
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h00000000);
		chk(q, exp, "read data");
	endtask

	// Four edges cover the two sync flops and the output flop
	task automatic drive(input logic [10:0] a, input logic [3:0] d);
		@(posedge clk);
		ana <= a;
		din <= d;
		repeat (4) @(posedge clk);
		#10;
	endtask

	task automatic outs(input logic [3:0] o, input logic p);
		chk({28'h0, oe}, {28'h0, o}, "out_en");
		chk({31'h0, pin_n}, {31'h0, p}, "fault pin");
	endtask

	initial begin
		#5000000;
		bad_count++;
		print_verdict();
	end

	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		#10;
		outs(4'h0, 1'b1);
		chk({31'h0, irq}, 32'h0, "irq after reset");
		foreach (regs[i]) rd(regs[i], 32'h00000000);
		rd(uvol_pkg::ADDR_LIVE, 32'h00000800);
		// ----------------------------------------------------------------
		// Table of steady cases
		// ----------------------------------------------------------------
		foreach (rows[i]) begin
			// Command first: enabling protection under a stale command
			// while the battery is low would latch the outputs off
			bus(1'b1, uvol_pkg::ADDR_CMD, {28'h0, rows[i].cmd});
			bus(1'b1, uvol_pkg::ADDR_CFG, {27'h0, rows[i].cfg});
			drive(rows[i].ana, 4'h0);
			outs(rows[i].oe, rows[i].pin);
		end
		// ----------------------------------------------------------------
		// Undervoltage with commands low, interrupt unmasked
		// ----------------------------------------------------------------
		rd(uvol_pkg::ADDR_STATUS, 32'h1);
		bus(1'b1, uvol_pkg::ADDR_MASK, 32'h1);
		drive(11'h001, 4'h0);
		outs(4'h0, 1'b0);
		chk({31'h0, irq}, 32'h1, "irq raised");
		rd(uvol_pkg::ADDR_STATUS, 32'h1);
		drive(11'h000, 4'h0);
		outs(4'h0, 1'b1);
		rd(uvol_pkg::ADDR_STATUS, 32'h1);
		rd(uvol_pkg::ADDR_STATUS, 32'h0);
		// Interrupt flop follows the cleared status one edge later
		@(posedge clk);
		#10;
		chk({31'h0, irq}, 32'h0, "irq cleared");
		// ----------------------------------------------------------------
		// Undervoltage with direct input on, latch and re-command
		// ----------------------------------------------------------------
		drive(11'h000, 4'h1);
		outs(4'h1, 1'b1);
		@(posedge clk);
		ana <= 11'h001;
		@(posedge clk);
		#10;
		chk({28'h0, oe}, 32'h1, "unsynced");
		drive(11'h001, 4'h1);
		outs(4'h0, 1'b0);
		bus(1'b1, uvol_pkg::ADDR_CFG, 32'h1E);
		rd(uvol_pkg::ADDR_CFG, 32'h1E);
		drive(11'h000, 4'h1);
		outs(4'h0, 1'b0);
		rd(uvol_pkg::ADDR_LIVE, 32'h00000010);
		drive(11'h000, 4'h0);
		drive(11'h000, 4'h1);
		outs(4'h1, 1'b1);
		bus(1'b1, uvol_pkg::ADDR_CFG, 32'h0);
		drive(11'h000, 4'h0);
		rd(uvol_pkg::ADDR_STATUS, 32'h1);
		// ----------------------------------------------------------------
		// Open load on ch1 (off) and ch2 (on), interrupt masked
		// ----------------------------------------------------------------
		bus(1'b1, uvol_pkg::ADDR_CMD, 32'h4);
		drive(11'h030, 4'h0);
		outs(4'h4, 1'b1);
		rd(uvol_pkg::ADDR_STATUS, 32'h0);
		drive(11'h7B0, 4'h0);
		outs(4'h4, 1'b0);
		chk({31'h0, irq}, 32'h0, "irq masked");
		rd(uvol_pkg::ADDR_STATUS, 32'h4);
		drive(11'h000, 4'h0);
		outs(4'h4, 1'b1);
		rd(uvol_pkg::ADDR_STATUS, 32'h4);
		rd(uvol_pkg::ADDR_STATUS, 32'h0);
		bus(1'b1, uvol_pkg::ADDR_CFG, 32'h4);
		drive(11'h7B0, 4'h0);
		outs(4'h4, 1'b1);
		rd(uvol_pkg::ADDR_STATUS, 32'h0);
		// ----------------------------------------------------------------
		// Unmapped address
		// ----------------------------------------------------------------
		bus(1'b0, 8'h14, 32'h0);
		chk({31'h0, e}, 32'h1, "slave error");
		print_verdict();
	end
endmodule
